// ### include/i2c_ctl_pkg.sv
// Shared constants, types and helper functions for the serial control port
package i2c_ctl_pkg;

    // Seven-bit bus address, chosen by the address select pin
    localparam logic [6:0] DEV_ADDR_SEL_HI = 7'h1b;
    localparam logic [6:0] DEV_ADDR_SEL_LO = 7'h1a;

    // Subaddress that appends four bytes to an opened long register
    localparam logic [7:0] APPEND_SUB      = 8'hfe;

    // Subaddress ranges that set the byte count of each register
    localparam logic [7:0] SHORT_LAST      = 8'h4f;
    localparam logic [7:0] BIQUAD_FIRST    = 8'h51;
    localparam logic [7:0] BIQUAD_LAST     = 8'h88;

    localparam logic [4:0] SHORT_BYTES     = 5'h01;
    localparam logic [4:0] WORD_BYTES      = 5'h04;
    localparam logic [4:0] BIQUAD_BYTES    = 5'h14;
    localparam logic [2:0] APPEND_BYTES    = 3'h4;
    localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

    localparam int         WORD_BITS       = 32;
    localparam int         MAX_WORDS       = 5;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } port_state_t;

    // Number of data bytes a subaddress holds
    function automatic logic [4:0] reg_bytes(input logic [7:0] sub);
        if (sub <= SHORT_LAST)
            reg_bytes = SHORT_BYTES;
        else if (sub >= BIQUAD_FIRST && sub <= BIQUAD_LAST)
            reg_bytes = BIQUAD_BYTES;
        else
            reg_bytes = WORD_BYTES;
    endfunction : reg_bytes

    // Keeps the implemented low bits of a read word, zero above them
    function automatic logic [31:0] width_mask(input logic [5:0] width);
        if (width >= 6'h20)
            width_mask = 32'hffffffff;
        else
            width_mask = ~(32'hffffffff << width);
    endfunction : width_mask

endpackage : i2c_ctl_pkg

// ### logic/i2c_pin_sampler.sv
// Bus pin sampler: clock edges, start and stop conditions
`timescale 1ns/10ps
`default_nettype none

module i2c_pin_sampler (
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic scl,
    input  wire logic sda_in,
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_det,
    output logic      stop_det,
    output logic      sda_bit
);

    logic scl_r;
    logic scl_nxt;
    logic sda_r;
    logic sda_nxt;

    always_comb begin
        scl_nxt = scl;
        sda_nxt = sda_in;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
        end else begin
            scl_r <= scl_nxt;
            sda_r <= sda_nxt;
        end
    end

    // Data may only change while the clock is low; a change with it high frames a transfer
    assign scl_rise  = scl & ~scl_r;
    assign scl_fall  = ~scl & scl_r;
    assign start_det = scl & scl_r & sda_r & ~sda_in;
    assign stop_det  = scl & scl_r & ~sda_r & sda_in;
    assign sda_bit   = sda_in;

endmodule : i2c_pin_sampler

`default_nettype wire

// ### logic/i2c_register_access_slave.sv
// Serial control port slave giving a bus master access to the device registers
`timescale 1ns/10ps
`default_nettype none

module i2c_register_access_slave #(
    parameter int MAX_WORDS = 5
) (
    input  wire logic                          mclk,
    input  wire logic                          nrst,
    input  wire logic                          scl,
    input  wire logic                          sda_in,
    output logic                               sda_out,
    output logic                               sda_oe,
    input  wire logic                          bus_address_select_pin,
    output logic                               wr_stb,
    output logic [7:0]                         wr_addr,
    output logic [MAX_WORDS*32-1:0]            wr_data,
    output logic                               flush_stb,
    output logic                               incr_open,
    output logic [7:0]                         rd_addr,
    output logic [2:0]                         rd_word,
    input  wire logic [31:0]                   rd_data,
    input  wire logic [5:0]                    rd_width
);
    import i2c_ctl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic sda_bit;

    i2c_pin_sampler u_pins (
        .mclk      (mclk),
        .nrst      (nrst),
        .scl       (scl),
        .sda_in    (sda_in),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_det (start_det),
        .stop_det  (stop_det),
        .sda_bit   (sda_bit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State

    port_state_t state_r,  state_nxt;
    logic [3:0]  bitc_r,   bitc_nxt;
    logic [7:0]  sh_r,     sh_nxt;
    logic [7:0]  tx_r,     tx_nxt;
    logic        oe_r,     oe_nxt;
    logic        rw_r,     rw_nxt;
    logic        first_r,  first_nxt;
    logic        wact_r,   wact_nxt;
    logic [7:0]  sub_r,    sub_nxt;
    logic [4:0]  bytec_r,  bytec_nxt;
    logic [2:0]  xfer_r,   xfer_nxt;
    logic        append_r, append_nxt;
    logic        drop_r,   drop_nxt;
    logic        open_r,   open_nxt;
    logic        stb_r,    stb_nxt;
    logic        flush_r,  flush_nxt;
    logic [31:0] buf_r   [MAX_WORDS];
    logic [31:0] buf_nxt [MAX_WORDS];

    logic [6:0]  dev_addr;
    logic [4:0]  sub_bytes;
    logic [31:0] rd_masked;
    logic [7:0]  tx_byte;
    logic        load_tx;
    logic        is_long;

    always_comb begin
        dev_addr  = bus_address_select_pin ? DEV_ADDR_SEL_HI : DEV_ADDR_SEL_LO;
        sub_bytes = reg_bytes(sub_r);
        is_long   = sub_bytes > WORD_BYTES;
        rd_masked = rd_data & width_mask(rd_width);
        if (sub_bytes == SHORT_BYTES)
            tx_byte = rd_masked[7:0];
        else
            tx_byte = rd_masked[8*(3-bytec_r[1:0]) +: 8];
        load_tx   = scl_fall && ((state_r == ST_ADDR_ACK && rw_r) || state_r == ST_TX_ACK);
    end

    always_comb begin
        state_nxt  = state_r;
        bitc_nxt   = bitc_r;
        sh_nxt     = sh_r;
        tx_nxt     = tx_r;
        oe_nxt     = oe_r;
        rw_nxt     = rw_r;
        first_nxt  = first_r;
        wact_nxt   = wact_r;
        sub_nxt    = sub_r;
        bytec_nxt  = bytec_r;
        xfer_nxt   = xfer_r;
        append_nxt = append_r;
        drop_nxt   = drop_r;
        open_nxt   = open_r;
        stb_nxt    = 1'b0;
        flush_nxt  = 1'b0;
        buf_nxt    = buf_r;

        if (start_det || stop_det) begin
            // End of a write transfer: keep only complete registers or a legal opening
            if (wact_r && bytec_r != 5'h00) begin
                if (!drop_r && is_long && xfer_r == APPEND_BYTES
                    && (append_r || bytec_r == WORD_BYTES)) begin
                    open_nxt = 1'b1;
                end else begin
                    bytec_nxt = 5'h00;
                    open_nxt  = 1'b0;
                    flush_nxt = 1'b1;
                end
            end
            wact_nxt   = 1'b0;
            append_nxt = 1'b0;
            drop_nxt   = 1'b0;
            xfer_nxt   = 3'h0;
            oe_nxt     = 1'b0;
            bitc_nxt   = 4'h0;
            first_nxt  = 1'b1;
            state_nxt  = start_det ? ST_ADDR : ST_IDLE;
        end else begin
            case (state_r)
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        sh_nxt   = {sh_r[6:0], sda_bit};
                        bitc_nxt = bitc_r + 4'h1;
                    end else if (scl_fall && bitc_r == BITS_PER_BYTE) begin
                        if (state_r == ST_ADDR) begin
                            if (sh_r[7:1] == dev_addr) begin
                                oe_nxt    = 1'b1;
                                rw_nxt    = sh_r[0];
                                state_nxt = ST_ADDR_ACK;
                                if (sh_r[0]) begin
                                    bytec_nxt = 5'h00;
                                    if (open_r) begin
                                        open_nxt  = 1'b0;
                                        flush_nxt = 1'b1;
                                    end
                                end
                            end else begin
                                state_nxt = ST_IDLE;
                            end
                        end else begin
                            oe_nxt    = 1'b1;
                            state_nxt = ST_RX_ACK;
                            if (first_r) begin
                                first_nxt = 1'b0;
                                wact_nxt  = 1'b1;
                                xfer_nxt  = 3'h0;
                                if (sh_r == APPEND_SUB) begin
                                    if (open_r)
                                        append_nxt = 1'b1;
                                    else
                                        drop_nxt = 1'b1;
                                end else begin
                                    sub_nxt   = sh_r;
                                    bytec_nxt = 5'h00;
                                    if (open_r) begin
                                        open_nxt  = 1'b0;
                                        flush_nxt = 1'b1;
                                    end
                                end
                            end else if (!drop_r) begin
                                if (append_r && xfer_r == APPEND_BYTES) begin
                                    drop_nxt   = 1'b1;
                                    append_nxt = 1'b0;
                                    open_nxt   = 1'b0;
                                    bytec_nxt  = 5'h00;
                                    flush_nxt  = 1'b1;
                                end else begin
                                    xfer_nxt = (xfer_r == 3'h7) ? xfer_r : xfer_r + 3'h1;
                                    if (sub_bytes == SHORT_BYTES)
                                        buf_nxt[0] = {24'h000000, sh_r};
                                    else
                                        buf_nxt[bytec_r[4:2]][8*(3-bytec_r[1:0]) +: 8] = sh_r;
                                    if (bytec_r + 5'h01 == sub_bytes) begin
                                        stb_nxt   = 1'b1;
                                        bytec_nxt = 5'h00;
                                        if (append_r) begin
                                            append_nxt = 1'b0;
                                            open_nxt   = 1'b0;
                                            drop_nxt   = 1'b1;
                                        end else begin
                                            sub_nxt = sub_r + 8'h01;
                                        end
                                    end else begin
                                        bytec_nxt = bytec_r + 5'h01;
                                    end
                                end
                            end
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        bitc_nxt = 4'h0;
                        if (rw_r) begin
                            state_nxt = ST_TX;
                        end else begin
                            oe_nxt    = 1'b0;
                            state_nxt = ST_RX;
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        oe_nxt    = 1'b0;
                        bitc_nxt  = 4'h0;
                        state_nxt = ST_RX;
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bitc_nxt = bitc_r + 4'h1;
                    end else if (scl_fall) begin
                        if (bitc_r == BITS_PER_BYTE) begin
                            oe_nxt    = 1'b0;
                            state_nxt = ST_TX_ACK;
                        end else begin
                            tx_nxt = {tx_r[6:0], 1'b0};
                            oe_nxt = ~tx_r[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise && sda_bit)
                        state_nxt = ST_IDLE;
                    else if (scl_fall)
                        state_nxt = ST_TX;
                    bitc_nxt = 4'h0;
                end
                ST_IDLE: begin
                    oe_nxt = 1'b0;
                end
                default: begin
                    state_nxt = ST_IDLE;
                    oe_nxt    = 1'b0;
                end
            endcase

            // Fetch the next read byte and step through the register, then the map
            if (load_tx) begin
                tx_nxt = tx_byte;
                oe_nxt = ~tx_byte[7];
                if (bytec_r + 5'h01 == sub_bytes) begin
                    bytec_nxt = 5'h00;
                    sub_nxt   = sub_r + 8'h01;
                end else begin
                    bytec_nxt = bytec_r + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r  <= ST_IDLE;
            bitc_r   <= 4'h0;
            sh_r     <= 8'h00;
            tx_r     <= 8'h00;
            oe_r     <= 1'b0;
            rw_r     <= 1'b0;
            first_r  <= 1'b1;
            wact_r   <= 1'b0;
            sub_r    <= 8'h00;
            bytec_r  <= 5'h00;
            xfer_r   <= 3'h0;
            append_r <= 1'b0;
            drop_r   <= 1'b0;
            open_r   <= 1'b0;
            stb_r    <= 1'b0;
            flush_r  <= 1'b0;
            for (int i = 0; i < MAX_WORDS; i++)
                buf_r[i] <= 32'h00000000;
        end else begin
            state_r  <= state_nxt;
            bitc_r   <= bitc_nxt;
            sh_r     <= sh_nxt;
            tx_r     <= tx_nxt;
            oe_r     <= oe_nxt;
            rw_r     <= rw_nxt;
            first_r  <= first_nxt;
            wact_r   <= wact_nxt;
            sub_r    <= sub_nxt;
            bytec_r  <= bytec_nxt;
            xfer_r   <= xfer_nxt;
            append_r <= append_nxt;
            drop_r   <= drop_nxt;
            open_r   <= open_nxt;
            stb_r    <= stb_nxt;
            flush_r  <= flush_nxt;
            buf_r    <= buf_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Pin is only ever pulled low; the clock line is never driven
    assign sda_out   = 1'b0;
    assign sda_oe    = oe_r;
    assign wr_stb    = stb_r;
    assign flush_stb = flush_r;
    assign incr_open = open_r;
    assign rd_addr   = sub_r;
    assign rd_word   = bytec_r[4:2];

    // Committed address is one behind once a sequential write has advanced
    always_comb begin
        wr_addr = (append_r || drop_r) ? sub_r : sub_r - 8'h01;
        for (int w = 0; w < MAX_WORDS; w++)
            wr_data[32*w +: 32] = buf_r[w];
    end

endmodule : i2c_register_access_slave

`default_nettype wire

// ### test/i2c_register_access_slave_checker.sv
// Pin and strobe checks for the serial control port slave
`timescale 1ns/10ps
`default_nettype none
module i2c_register_access_slave_checker #(
    parameter int MAX_WORDS = 5
) (
    input wire logic                   mclk,
    input wire logic                   nrst,
    input wire logic                   scl,
    input wire logic                   sda_in,
    input wire logic                   sda_out,
    input wire logic                   sda_oe,
    input wire logic                   bus_address_select_pin,
    input wire logic                   wr_stb,
    input wire logic [7:0]             wr_addr,
    input wire logic [MAX_WORDS*32-1:0] wr_data,
    input wire logic                   flush_stb,
    input wire logic                   incr_open,
    input wire logic [7:0]             rd_addr,
    input wire logic [2:0]             rd_word,
    input wire logic [31:0]            rd_data,
    input wire logic [5:0]             rd_width
);
    import i2c_ctl_pkg::*;
    logic [1:0] recent_r;
    logic [1:0] recent_nxt;
    always_comb begin
        recent_nxt = {recent_r[0], wr_stb | flush_stb};
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            recent_r <= 2'h0;
        end else begin
            recent_r <= recent_nxt;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_stop;
        scl && $rose(sda_in);
    endsequence
    sequence s_quiet;
        !sda_oe [*8];
    endsequence
    chk_open_drain: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    chk_no_stretch: assert property ($changed(sda_oe) |-> !scl)
        else $error("data pin moved while bus clock high");
    chk_ack_hold: assert property ($rose(sda_oe) |-> sda_oe [*8])
        else $error("acknowledge or data bit too short");
    chk_stop_quiet: assert property (s_stop |=> s_quiet)
        else $error("data pin pulled after stop");
    chk_stb_pulse: assert property (wr_stb |=> !wr_stb)
        else $error("commit strobe longer than one cycle");
    chk_stb_clk_low: assert property (wr_stb |-> !scl)
        else $error("commit outside bus clock low phase");
    chk_flush_pulse: assert property (flush_stb |=> !flush_stb)
        else $error("flush strobe longer than one cycle");
    chk_flush_excl: assert property (!(wr_stb && flush_stb))
        else $error("commit and flush together");
    chk_stb_no_append: assert property (wr_stb |-> wr_addr != APPEND_SUB)
        else $error("commit to append subaddress");
    chk_open_end: assert property ($fell(incr_open) |->
        (recent_r != 2'h0) or (##[0:2] (wr_stb || flush_stb)))
        else $error("open register closed without commit or flush");
endmodule : i2c_register_access_slave_checker
bind i2c_register_access_slave i2c_register_access_slave_checker #(
    .MAX_WORDS(MAX_WORDS)
) i_chk (
    .mclk(mclk), .nrst(nrst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .bus_address_select_pin(bus_address_select_pin),
    .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .flush_stb(flush_stb),
    .incr_open(incr_open), .rd_addr(rd_addr), .rd_word(rd_word),
    .rd_data(rd_data), .rd_width(rd_width)
);
`default_nettype wire

// ### test/i2c_master_model.sv
// Bus master model: open-drain data line and bus clock, bit-level tasks
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
    input  wire logic mclk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_rel
);
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic hq(input int n);
        repeat (n) @(negedge mclk);
    endtask : hq
    // Start or repeated start: data falls while clock high
    task automatic start_c;
        sda_rel = 1'b1;
        hq(4);
        scl = 1'b1;
        hq(4);
        sda_rel = 1'b0;
        hq(4);
        scl = 1'b0;
        hq(2);
    endtask : start_c
    task automatic stop_c;
        sda_rel = 1'b0;
        hq(4);
        scl = 1'b1;
        hq(4);
        sda_rel = 1'b1;
        hq(4);
    endtask : stop_c
    // Data only changes in the clock low phase; sampled mid high phase
    task automatic bit_x(input logic b, output logic r);
        sda_rel = b;
        hq(4);
        scl = 1'b1;
        hq(4);
        r = sda;
        hq(4);
        scl = 1'b0;
        hq(2);
    endtask : bit_x
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask : wbyte
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(nack, r);
    endtask : rbyte
endmodule : i2c_master_model
`default_nettype wire

// ### test/i2c_register_access_slave_tb.sv
// Self-checking bench for the serial control port slave
`timescale 1ns/10ps
`default_nettype none
module i2c_register_access_slave_tb;
    import i2c_ctl_pkg::*;
    localparam int NW = 5;
    localparam int LIMIT = 60000;
    logic             mclk, nrst, scl, sda_rel, sda, sda_out, sda_oe, sel;
    logic             wr_stb, flush_stb, incr_open;
    logic [7:0]       wr_addr, rd_addr;
    logic [NW*32-1:0] wr_data;
    logic [2:0]       rd_word;
    logic [31:0]      rd_data;
    logic [5:0]       rd_width;
    logic [7:0]       tx[$];
    logic [7:0]       sa_q[$];
    logic [NW*32-1:0] sd_q[$];
    logic [6:0]       dev;
    int               n_fail = 0;
    int               cmp_count = 0;
    int               fl_n = 0;
    int               cyc = 0;
    assign sda = sda_rel & !(sda_oe && !sda_out);
    assign rd_data = {rd_addr, ~rd_addr, 5'h00, rd_word, rd_addr ^ 8'h5a};
    assign rd_width = (rd_addr == 8'h90) ? 6'h0c : 6'h20;
    i2c_register_access_slave #(.MAX_WORDS(NW)) i_dut (
        .mclk(mclk), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .bus_address_select_pin(sel), .wr_stb(wr_stb),
        .wr_addr(wr_addr), .wr_data(wr_data), .flush_stb(flush_stb),
        .incr_open(incr_open), .rd_addr(rd_addr), .rd_word(rd_word),
        .rd_data(rd_data), .rd_width(rd_width));
    i2c_master_model i_mst (.mclk(mclk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (wr_stb === 1'b1) begin
            sa_q.push_back(wr_addr);
            sd_q.push_back(wr_data);
        end
        if (flush_stb === 1'b1) fl_n++;
        if (cyc == LIMIT) begin
            n_fail++;
            close_out();
        end
    end
    task automatic chk(input logic [NW*32-1:0] got, input logic [NW*32-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : chk
    task automatic fill(input int n, input logic [7:0] b);
        tx.delete();
        for (int i = 0; i < n; i++) tx.push_back(b + 8'(i));
    endtask : fill
    task automatic send(input logic [7:0] sub, input logic stop);
        logic a;
        i_mst.start_c();
        i_mst.wbyte({dev, 1'b0}, a);
        chk(a, 1);
        i_mst.wbyte(sub, a);
        chk(a, 1);
        foreach (tx[i]) begin
            i_mst.wbyte(tx[i], a);
            chk(a, 1);
        end
        if (stop) i_mst.stop_c();
    endtask : send
    // Pops one commit and compares the lanes that nb bytes from tx[off] fill
    task automatic got_reg(input logic [7:0] sub, input int nb, input int off);
        logic [NW*32-1:0] e, m, d;
        int p;
        e = '0;
        m = '0;
        for (int i = 0; i < nb; i++) begin
            p = (nb == 1) ? 0 : (i / 4) * 32 + (3 - i % 4) * 8;
            e[p +: 8] = tx[off + i];
            m[p +: 8] = 8'hff;
        end
        chk(sa_q.size() != 0, 1);
        d = sd_q.pop_front();
        chk(sa_q.pop_front(), sub);
        chk(d & m, e);
    endtask : got_reg
    task automatic rd(input logic [7:0] sub, input int n);
        logic a;
        logic [7:0] b, s;
        logic [31:0] w;
        int k;
        int nb;
        tx.delete();
        send(sub, 0);
        i_mst.start_c();
        i_mst.wbyte({dev, 1'b1}, a);
        chk(a, 1);
        s = sub;
        k = 0;
        for (int i = 0; i < n; i++) begin
            i_mst.rbyte(i == n - 1, b);
            nb = (s <= SHORT_LAST) ? 1 : (s >= BIQUAD_FIRST && s <= BIQUAD_LAST) ? 20 : 4;
            w = {s, ~s, 5'h00, 3'(k / 4), s ^ 8'h5a};
            if (s == 8'h90) w = w & 32'h00000fff;
            if (nb == 1) begin
                chk(b, w[7:0]);
            end else begin
                chk(b, w[31 - 8 * (k % 4) -: 8]);
            end
            k++;
            if (k == nb) begin
                k = 0;
                s++;
            end
        end
        i_mst.stop_c();
    endtask : rd
    task automatic t_short;
        logic a;
        fill(16, 8'ha0);
        send(8'h10, 1);
        for (int k = 0; k < 16; k++) got_reg(8'h10 + 8'(k), 1, k);
        sel = 1'b0;
        i_mst.start_c();
        i_mst.wbyte({dev, 1'b0}, a);
        chk(a, 0);
        i_mst.stop_c();
        dev = 7'h1a;
        fill(1, 8'h5c);
        send(8'h08, 1);
        got_reg(8'h08, 1, 0);
        sel = 1'b1;
        dev = 7'h1b;
        chk(sa_q.size(), 0);
        $display("t_short done");
    endtask : t_short
    task automatic t_long;
        int f0;
        fill(20, 8'h30);
        send(8'h51, 1);
        got_reg(8'h51, 20, 0);
        f0 = fl_n;
        fill(12, 8'h70);
        send(8'h52, 0);
        fill(4, 8'h90);
        send(8'h90, 1);
        got_reg(8'h90, 4, 0);
        fill(6, 8'hc0);
        send(8'h91, 1);
        got_reg(8'h91, 4, 0);
        chk(fl_n, f0 + 2);
        chk(sa_q.size(), 0);
        $display("t_long done");
    endtask : t_long
    task automatic t_incr;
        int f0;
        logic a;
        logic [7:0] b;
        fill(4, 8'h40);
        send(8'h51, 1);
        chk(incr_open, 1);
        for (int k = 0; k < 4; k++) begin
            chk(sa_q.size(), 0);
            fill(4, 8'h44 + 8'(4 * k));
            send(APPEND_SUB, 1);
        end
        fill(20, 8'h40);
        got_reg(8'h51, 20, 0);
        chk(incr_open, 0);
        for (int m = 0; m < 4; m++) begin
            f0 = fl_n;
            fill((m == 3) ? 5 : 4, 8'h20);
            send(8'h51, 1);
            chk(incr_open, m != 3);
            fill((m == 1) ? 1 : 3, 8'h0f);
            case (m)
                0: send(APPEND_SUB, 1);
                1: begin
                    send(8'h05, 1);
                    got_reg(8'h05, 1, 0);
                end
                2: begin
                    i_mst.start_c();
                    i_mst.wbyte({dev, 1'b1}, a);
                    i_mst.rbyte(1'b1, b);
                    i_mst.stop_c();
                end
                default: ;
            endcase
            chk(fl_n, f0 + 1);
            chk(incr_open, 0);
            chk(sa_q.size(), 0);
        end
        $display("t_incr done");
    endtask : t_incr
    task automatic t_read;
        rd(8'h4e, 6);
        rd(8'h90, 5);
        rd(8'h88, 9);
        $display("t_read done");
    endtask : t_read
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    initial begin
        nrst = 1'b0;
        sel = 1'b1;
        dev = 7'h1b;
        repeat (8) @(negedge mclk);
        nrst = 1'b1;
        repeat (2) @(negedge mclk);
        t_short();
        t_long();
        t_incr();
        t_read();
        close_out();
    end
endmodule : i2c_register_access_slave_tb
`default_nettype wire
